// >>> include/phi_pkg.sv
// Package: constants and carriers for the identification header registers
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package phi_pkg;
  localparam int FUNC_COUNT = 4;
  localparam logic [2:0] FUNC_W_MAX = 3'h3;
  // Dword indices (register offset bits 7:2)
  localparam logic [5:0] IDX_ID = 6'h00;
  localparam logic [5:0] IDX_CLASS = 6'h02;
  localparam logic [5:0] IDX_HTYPE = 6'h03;
  localparam logic [5:0] IDX_SUBSYS = 6'h0b;
  // Byte offsets within the header
  localparam logic [7:0] OFS_IDENTITY = 8'h02;
  localparam logic [7:0] OFS_CLASS = 8'h09;
  localparam logic [7:0] OFS_REVISION = 8'h08;
  localparam logic [7:0] OFS_HTYPE = 8'h0e;
  localparam logic [7:0] OFS_SUBVEN = 8'h2c;
  localparam logic [7:0] OFS_SUBID = 8'h2e;
  // Fixed field values
  localparam logic [7:0] CLASS_BASE = 8'h06;
  localparam logic [7:0] CLASS_SUB = 8'h00;
  localparam logic [7:0] CLASS_PROG = 8'h00;
  localparam logic HTYPE_MULTI = 1'b1;
  localparam logic [6:0] HTYPE_LAYOUT = 7'h00;
  localparam logic [31:0] READ_NO_FUNC = 32'hffff_ffff;
  localparam logic [31:0] READ_RESERVED = 32'h0000_0000;
  // Subsystem field positions within dword 0x2c
  localparam int SUBVEN_LSB = 0;
  localparam int SUBID_LSB = 16;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] func;
    logic [5:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } phi_req_s;

  typedef struct packed {
    logic [31:0] subsys;
    logic [3:0] written;
    logic [31:0] rdata;
    logic rvalid;
  } phi_state_s;
endpackage

// >>> logic/phi_header_regs.sv
// Design: identification part of a four-function type-0 config header
`timescale 1ns/100ps
`default_nettype none
module phi_header_regs #(
  // Arbitrary neutral values, not any real maker's codes
  parameter logic [15:0] FUNC_ID_BASE = 16'h1230,
  parameter logic [7:0] REVISION = 8'h3c,
  parameter logic [15:0] MAKER_CODE = 16'h5a5a
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire phi_pkg::phi_req_s req_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out
);
  // -------------------------------------------------------------------------
  // Read decode
  // -------------------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [2:0] func,
                                            input logic [5:0] idx,
                                            input logic [31:0] subsys);
    logic [15:0] fid;
    fid = FUNC_ID_BASE + {14'h0000, func[1:0]};
    read_word = phi_pkg::READ_RESERVED;
    if (func > phi_pkg::FUNC_W_MAX) begin
      read_word = phi_pkg::READ_NO_FUNC;
    end else begin
      case (idx)
        phi_pkg::IDX_ID: read_word = {fid, 16'h0000};
        phi_pkg::IDX_CLASS: read_word = {phi_pkg::CLASS_BASE,
          phi_pkg::CLASS_SUB, phi_pkg::CLASS_PROG, REVISION};
        phi_pkg::IDX_HTYPE: read_word = {8'h00, phi_pkg::HTYPE_MULTI,
          phi_pkg::HTYPE_LAYOUT, 16'h0000};
        phi_pkg::IDX_SUBSYS: read_word = subsys;
        default: read_word = phi_pkg::READ_RESERVED;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  phi_pkg::phi_state_s st_r;
  phi_pkg::phi_state_s st_nxt;
  logic sub_hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    // Bottom vendor, top identity word; shared by all functions
    sub_hit = req_in.wr && req_in.func <= phi_pkg::FUNC_W_MAX &&
              req_in.idx == phi_pkg::IDX_SUBSYS;
    for (int b = 0; b < 4; b++) begin
      // Lock per byte; later writes are silently ignored
      if (sub_hit && req_in.be[b] && !st_r.written[b]) begin
        st_nxt.subsys[8*b +: 8] = req_in.wdata[8*b +: 8];
        st_nxt.written[b] = 1'b1;
      end
    end
    if (req_in.rd) begin
      st_nxt.rdata = read_word(req_in.func, req_in.idx, st_r.subsys);
      st_nxt.rvalid = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_r.subsys <= {MAKER_CODE, MAKER_CODE};
      st_r.written <= 4'h0;
      st_r.rdata <= 32'h0000_0000;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign rvalid_out = st_r.rvalid;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  property p_no_func;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func > 3'h3 |=> rdata_out == 32'hffff_ffff;
  endproperty
  a_no_func: assert property (p_no_func) else $error("bad func read");

  property p_class;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == 6'h02
      |=> rdata_out[31:8] == 24'h060000;
  endproperty
  a_class: assert property (p_class) else $error("class wrong");

  property p_htype;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == 6'h03
      |=> rdata_out[23:16] == 8'h80;
  endproperty
  a_htype: assert property (p_htype) else $error("header type wrong");

  property p_id;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == 6'h00
      |=> rdata_out[31:16] == FUNC_ID_BASE + 16'($past(req_in.func[1:0]));
  endproperty
  a_id: assert property (p_id) else $error("identity wrong");

  property p_lock;
    @(posedge mclk_in) disable iff (reset_in)
    st_r.written[0] |=> st_r.subsys[7:0] == $past(st_r.subsys[7:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("byte rewritten");

  property p_first;
    @(posedge mclk_in) disable iff (reset_in)
    sub_hit && req_in.be[2] && !st_r.written[2]
      |=> st_r.written[2] && st_r.subsys[23:16] == $past(req_in.wdata[23:16]);
  endproperty
  a_first: assert property (p_first) else $error("first write lost");

  property p_resv;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == 6'h3f
      |=> rdata_out == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved not zero");

  property p_rv;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd |=> rvalid_out ##1 (rvalid_out == $past(req_in.rd));
  endproperty
  a_rv: assert property (p_rv) else $error("read valid wrong");

  // -------------------------------------------------------------------------
  // Field, lock, reset and read-output checks
  // -------------------------------------------------------------------------
  property p_sub;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == phi_pkg::IDX_CLASS
      |=> rdata_out[23:16] == phi_pkg::CLASS_SUB;
  endproperty
  a_sub: assert property (p_sub) else $error("sub-class wrong");

  property p_prog;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == phi_pkg::IDX_CLASS
      |=> rdata_out[15:8] == phi_pkg::CLASS_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("prog interface wrong");

  property p_rev;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == phi_pkg::IDX_CLASS
      |=> rdata_out[7:0] == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");

  property p_layout;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == phi_pkg::IDX_HTYPE
      |=> rdata_out[22:16] == phi_pkg::HTYPE_LAYOUT;
  endproperty
  a_layout: assert property (p_layout) else $error("layout wrong");

  property p_vid_low;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.rd && req_in.func < 3'h4 && req_in.idx == phi_pkg::IDX_ID
      |=> rdata_out[15:0] == 16'h0000;
  endproperty
  a_vid_low: assert property (p_vid_low) else $error("low half wrong");

  property p_ro;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.wr && req_in.idx != phi_pkg::IDX_SUBSYS
      |=> st_r.subsys == $past(st_r.subsys);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write landed");

  property p_drop;
    @(posedge mclk_in) disable iff (reset_in)
    req_in.wr && req_in.func > 3'h3
      |=> st_r.subsys == $past(st_r.subsys) &&
          st_r.written == $past(st_r.written);
  endproperty
  a_drop: assert property (p_drop) else $error("absent func written");

  property p_rst_val;
    @(posedge mclk_in) disable iff (reset_in)
    $fell(reset_in)
      |-> st_r.subsys == {MAKER_CODE, MAKER_CODE} && st_r.written == 4'h0;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value");

  property p_lock3;
    @(posedge mclk_in) disable iff (reset_in)
    st_r.written[3] |=> st_r.subsys[31:24] == $past(st_r.subsys[31:24]);
  endproperty
  a_lock3: assert property (p_lock3) else $error("top byte rewritten");

  property p_first0;
    @(posedge mclk_in) disable iff (reset_in)
    sub_hit && req_in.be[0] && !st_r.written[0]
      |=> st_r.written[0] && st_r.subsys[7:0] == $past(req_in.wdata[7:0]);
  endproperty
  a_first0: assert property (p_first0) else $error("vendor byte lost");

  property p_lock_keep;
    @(posedge mclk_in) disable iff (reset_in)
    st_r.written[1] |=> st_r.written[1];
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock lost");

  property p_rd_stand;
    @(posedge mclk_in) disable iff (reset_in)
    !req_in.rd |=> $stable(rdata_out);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("data moved");

  property p_no_rv;
    @(posedge mclk_in) disable iff (reset_in)
    !req_in.rd |=> !rvalid_out;
  endproperty
  a_no_rv: assert property (p_no_rv) else $error("stray read valid");
endmodule
`default_nettype wire

// >>> verif/tb_phi_header_regs.sv
// Testbench: configuration reads and writes of the identification header
`timescale 1ns/100ps
`default_nettype none
module tb_phi_header_regs;
  // ----------------------------------------------------------------
  // Clock, reset and design
  // ----------------------------------------------------------------
  // Arbitrary codes, not any real part's
  localparam logic [15:0] BASE = 16'h1230;
  localparam logic [7:0] REV = 8'h3c;
  localparam logic [15:0] MAKER = 16'h5a5a;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  phi_pkg::phi_req_s req = '0;
  logic [31:0] rdata;
  logic rvalid;
  int err_total = 0;
  int n_compared = 0;
  always #2 mclk_in = ~mclk_in;
  phi_header_regs #(.FUNC_ID_BASE(BASE), .REVISION(REV),
                    .MAKER_CODE(MAKER)) dut (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .req_in(req),
    .rdata_out(rdata),
    .rvalid_out(rvalid)
  );
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle edge after each access, so no signal changes twice in a step
  task automatic wr(input logic [2:0] f, input logic [5:0] i,
                    input logic [3:0] b, input logic [31:0] d);
    phi_pkg::phi_req_s r;
    r = '0;
    r.wr = 1'b1;
    r.func = f;
    r.idx = i;
    r.be = b;
    r.wdata = d;
    req = r;
    @(posedge mclk_in);
    #1;
    req = '0;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic rd(input logic [2:0] f, input logic [5:0] i,
                    input logic [31:0] exp);
    phi_pkg::phi_req_s r;
    r = '0;
    r.rd = 1'b1;
    r.func = f;
    r.idx = i;
    req = r;
    @(posedge mclk_in);
    #1;
    req = '0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
    @(posedge mclk_in);
    #1;
    chk({31'h0, rvalid}, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic results();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    for (int f = 0; f < 4; f++) begin
      wr(3'(f), 6'h00, 4'hf, 32'h0);
      rd(3'(f), 6'h00, {BASE + 16'(f), 16'h0});
      rd(3'(f), 6'h02, {8'h06, 8'h00, 8'h00, REV});
      rd(3'(f), 6'h03, 32'h0080_0000);
      rd(3'(f), 6'h0b, {MAKER, MAKER});
    end
    for (int f = 4; f < 8; f++) begin
      wr(3'(f), 6'h0b, 4'hf, 32'h0);
      rd(3'(f), 6'h0b, 32'hffff_ffff);
    end
    wr(3'h0, 6'h01, 4'hf, 32'hffff_ffff);
    rd(3'h0, 6'h01, 32'h0);
    rd(3'h0, 6'h3f, 32'h0);
    rd(3'h1, 6'h0b, {MAKER, MAKER});
    wr(3'h0, 6'h0b, 4'h1, 32'h0000_0011);
    wr(3'h1, 6'h0b, 4'h1, 32'h0000_0022);
    rd(3'h2, 6'h0b, {MAKER, MAKER[15:8], 8'h11});
    wr(3'h3, 6'h0b, 4'he, 32'hccdd_ee33);
    wr(3'h0, 6'h0b, 4'hf, 32'h4455_6677);
    rd(3'h0, 6'h0b, 32'hccdd_ee11);
    // Second reset must unlock every byte again
    reset_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    rd(3'h1, 6'h0b, {MAKER, MAKER});
    wr(3'h2, 6'h0b, 4'hf, 32'h1234_5678);
    rd(3'h3, 6'h0b, 32'h1234_5678);
    results();
  end
  // Run takes well under a microsecond; generous margin
  initial begin
    #20000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
